// *** rtl/boot_loader_pkg.sv ***
`default_nettype none
package boot_loader_pkg;
   // serial load link and clock timing
   localparam int CLK_HZ         = 125_000_000;
   localparam int CLK_MHZ        = 125;
   localparam int BAUD           = 921_600;
   localparam int BIT_CYC        = (CLK_HZ + BAUD / 2) / BAUD; // nearest whole cycle
   localparam int HALF_CYC       = BIT_CYC / 2;
   localparam int DATA_BITS      = 8;
   localparam int FRAME_BITS     = DATA_BITS + 2;              // start, data, one stop
   localparam int BREAK_CYC      = FRAME_BITS * BIT_CYC;
   localparam int BREAK_WAIT_US  = 100;
   localparam int BREAK_WAIT_CYC = BREAK_WAIT_US * CLK_MHZ;
   localparam int SETTLE_CYC     = 3;

   localparam logic [7:0]  BIT_LAST  = 8'(BIT_CYC - 1);
   localparam logic [7:0]  HALF_LAST = 8'(HALF_CYC - 1);
   localparam logic [2:0]  IDX_LAST  = 3'(DATA_BITS - 1);
   localparam logic [10:0] BRK_LIMIT = 11'(BREAK_CYC);
   localparam logic [1:0]  SETTLE_LAST = 2'(SETTLE_CYC - 1);

   // boot strap pin codes, bit 2 down to bit 0
   localparam logic [2:0] STRAP_LOAD = 3'h4;
   localparam logic [2:0] STRAP_LOR  = 3'h2;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_RXDATA  = 8'h08;
   localparam logic [7:0] OFS_COUNT   = 8'h0c;
   localparam logic [7:0] OFS_FLASHIO = 8'h10;

   // field positions
   localparam int CTRL_FLASH_EN = 0;
   localparam int FIO_SCLK      = 0;
   localparam int FIO_CS_N      = 1;
   localparam int FIO_MOSI      = 2;
   localparam int FIO_MISO      = 3;
   localparam int STS_STATE     = 0;
   localparam int STS_RXVALID   = 2;
   localparam int STS_OVERRUN   = 3;
   localparam int STS_FRAMEERR  = 4;
   localparam int STS_BREAK     = 5;
   localparam int STS_FOURWIRE  = 6;
   localparam int STS_DBGAVAIL  = 7;

   // reset values
   localparam logic [2:0] FIO_RESET = 3'h2; // chip select idle high

   typedef enum logic [1:0] {
      BOOT_STRAP  = 2'b00,
      BOOT_LOAD   = 2'b01,
      BOOT_DETECT = 2'b10,
      BOOT_RUN    = 2'b11
   } boot_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;
endpackage : boot_loader_pkg
`default_nettype wire

// *** rtl/uart_frame_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_frame_rx (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       clkEn,
   input  wire logic       rxLine,
   output logic [7:0]      byteData,
   output logic            byteValid,
   output logic            frameErr,
   output logic            breakDet
);
   typedef struct packed {
      boot_loader_pkg::rx_state_t st;
      logic [7:0]                 bitCnt;
      logic [2:0]                 idx;
      logic [7:0]                 shift;
      logic [7:0]                 data;
      logic                       valid;
      logic                       ferr;
      logic                       armed;
      logic [10:0]                lowCnt;
      logic                       brk;
   } rx_reg_t;

   rx_reg_t q;
   rx_reg_t d;

   // frame receiver and break watch; a frame error disarms until the line idles
   // so a held break is reported once, not as a stream of bad frames
   always_comb begin
      d       = q;
      d.valid = 1'b0;
      d.ferr  = 1'b0;
      if (rxLine) begin
         d.lowCnt = '0;
         d.armed  = 1'b1;
      end else if (q.lowCnt != boot_loader_pkg::BRK_LIMIT) begin
         d.lowCnt = q.lowCnt + 11'h1;
      end
      d.brk = !rxLine && (q.lowCnt == boot_loader_pkg::BRK_LIMIT); // R15
      unique case (q.st)
         boot_loader_pkg::RX_IDLE: begin
            if (!rxLine && q.armed) begin
               d.st     = boot_loader_pkg::RX_START;
               d.bitCnt = '0;
            end
         end
         boot_loader_pkg::RX_START: begin
            if (q.bitCnt == boot_loader_pkg::HALF_LAST) begin
               d.bitCnt = '0;
               d.idx    = '0;
               d.st     = rxLine ? boot_loader_pkg::RX_IDLE : boot_loader_pkg::RX_DATA;
            end else begin
               d.bitCnt = q.bitCnt + 8'h1;
            end
         end
         boot_loader_pkg::RX_DATA: begin
            if (q.bitCnt == boot_loader_pkg::BIT_LAST) begin
               d.bitCnt = '0;
               d.shift  = {rxLine, q.shift[7:1]}; // R12
               d.idx    = q.idx + 3'h1;
               if (q.idx == boot_loader_pkg::IDX_LAST) begin
                  d.st = boot_loader_pkg::RX_STOP;
               end
            end else begin
               d.bitCnt = q.bitCnt + 8'h1;
            end
         end
         boot_loader_pkg::RX_STOP: begin
            if (q.bitCnt == boot_loader_pkg::BIT_LAST) begin
               d.st = boot_loader_pkg::RX_IDLE;
               if (rxLine) begin
                  d.valid = 1'b1; // R12
                  d.data  = q.shift;
               end else begin
                  d.ferr  = 1'b1;
                  d.armed = 1'b0;
               end
            end else begin
               d.bitCnt = q.bitCnt + 8'h1;
            end
         end
      endcase
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else if (clkEn) begin
         q <= d;
      end
   end

   assign byteData  = q.data;
   assign byteValid = q.valid;
   assign frameErr  = q.ferr;
   assign breakDet  = q.brk;

   // helper: consecutive enabled low samples, read only by the checks below
   logic [11:0] lowRun;
   always_ff @(posedge mclk) begin
      if (rst || (clkEn && rxLine)) begin
         lowRun <= '0;
      end else if (clkEn && lowRun != 12'hfff) begin
         lowRun <= lowRun + 12'h1;
      end
   end

   sequence s_stop_high;
      q.st == boot_loader_pkg::RX_STOP && q.bitCnt == boot_loader_pkg::BIT_LAST
         && clkEn && rxLine;
   endsequence

   sequence s_stop_low;
      q.st == boot_loader_pkg::RX_STOP && q.bitCnt == boot_loader_pkg::BIT_LAST
         && clkEn && !rxLine;
   endsequence

   a_break_after_frame: assert property (@(posedge mclk) disable iff (rst) // R15
      breakDet |-> lowRun > 12'(boot_loader_pkg::BREAK_CYC))
      else $error("break flagged before a full frame of low line");

   a_stop_gives_byte: assert property (@(posedge mclk) disable iff (rst) // R12
      s_stop_high |=> byteValid && !frameErr && byteData == $past(q.shift))
      else $error("valid stop bit did not deliver the byte");

   a_stop_low_error: assert property (@(posedge mclk) disable iff (rst) // R12
      s_stop_low |=> frameErr && !byteValid)
      else $error("low stop bit not reported as framing error");
endmodule : uart_frame_rx
`default_nettype wire

// *** rtl/boot_mode_serial_image_loader.sv ***
// Overview of operation
// R1 - image bytes are written from flash address zero
// R2 - only the programmer drives flash lines then
// R3 - flash lines undriven while device in reset
// R4 - load straps: serial load, wait forever
// R5 - operator restores functional straps after loading
// R6 - serial load puts debug port four-wire
// R7 - load-or-run straps: look for receive break
// R8 - break enters load, otherwise run directly
// R9 - load-or-run keeps all four debug signals
// R10 - fixture forces straps with temporary pulls
// R11 - fixture never leaves straps in load setting
// R12 - link is 921600 baud, 8N1, positive
// R13 - only transmit and receive, no handshake
// R14 - programmer restarts device through active-low reset
// R15 - break is low longer than one frame
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module boot_mode_serial_image_loader #(
   parameter int BREAK_WAIT_CYC = boot_loader_pkg::BREAK_WAIT_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  bootStrapPins,
   input  wire logic        uartRx,
   output logic             uartTx,
   input  wire logic        flashMiso,
   output logic             flashSclk,
   output logic             flashCsN,
   output logic             flashMosi,
   output logic             flashOe,
   output logic [1:0]       bootState,
   output logic             serialLoadMode,
   output logic             runMode,
   output logic             jtagFourWire,
   output logic             debugPortAvail
);
   localparam logic [23:0] WAIT_LAST = 24'(BREAK_WAIT_CYC - 1);

   typedef struct packed {
      boot_loader_pkg::boot_state_t st;
      logic [1:0]                   settle;
      logic [2:0]                   strap;
      logic [23:0]                  waitCnt;
      logic                         fourWire;
      logic                         dbgAvail;
      logic                         flashEn;
      logic [2:0]                   fio;
      logic                         rxValid;
      logic [7:0]                   rxByte;
      logic                         overrun;
      logic                         ferr;
      logic                         brkSeen;
      logic [23:0]                  count;
      logic                         rdy;
      logic [31:0]                  rdata;
      logic [2:0]                   strapM;
      logic [2:0]                   strapS;
      logic                         rxM;
      logic                         rxS;
      logic                         misoM;
      logic                         misoS;
   } top_reg_t;

   top_reg_t    q;
   top_reg_t    d;
   logic [7:0]  rxData;
   logic        rxDone;
   logic        rxFerr;
   logic        rxBreak;
   logic        acc;
   logic        wrHit;
   logic        rdHit;
   logic        mapped;
   logic [31:0] rdMux;

   // receiver sees the line only after the two-stage synchroniser
   uart_frame_rx rxUnit (
      .mclk      (mclk),
      .rst       (rst),
      .clkEn     (clkEn),
      .rxLine    (q.rxS),
      .byteData  (rxData),
      .byteValid (rxDone),
      .frameErr  (rxFerr),
      .breakDet  (rxBreak)
   );

   // apb decode; the access completes on the first enabled access cycle
   assign acc    = psel && penable && q.rdy;
   assign wrHit  = acc && pwrite;
   assign rdHit  = acc && !pwrite;
   assign mapped = paddr == boot_loader_pkg::OFS_CTRL || paddr == boot_loader_pkg::OFS_STATUS
                   || paddr == boot_loader_pkg::OFS_RXDATA || paddr == boot_loader_pkg::OFS_COUNT
                   || paddr == boot_loader_pkg::OFS_FLASHIO;

   // read data is captured ahead of the access phase so prdata is a flop output
   always_comb begin
      rdMux = '0;
      unique case (paddr)
         boot_loader_pkg::OFS_CTRL: begin
            rdMux[boot_loader_pkg::CTRL_FLASH_EN] = q.flashEn;
         end
         boot_loader_pkg::OFS_STATUS: begin
            rdMux[boot_loader_pkg::STS_STATE +: 2]  = q.st;
            rdMux[boot_loader_pkg::STS_RXVALID]     = q.rxValid;
            rdMux[boot_loader_pkg::STS_OVERRUN]     = q.overrun;
            rdMux[boot_loader_pkg::STS_FRAMEERR]    = q.ferr;
            rdMux[boot_loader_pkg::STS_BREAK]       = q.brkSeen;
            rdMux[boot_loader_pkg::STS_FOURWIRE]    = q.fourWire;
            rdMux[boot_loader_pkg::STS_DBGAVAIL]    = q.dbgAvail;
         end
         boot_loader_pkg::OFS_RXDATA: begin
            rdMux[7:0] = q.rxByte;
         end
         boot_loader_pkg::OFS_COUNT: begin
            rdMux[23:0] = q.count;
         end
         boot_loader_pkg::OFS_FLASHIO: begin
            rdMux[boot_loader_pkg::FIO_SCLK +: 3] = q.fio;
            rdMux[boot_loader_pkg::FIO_MISO]      = q.misoS;
         end
         default: begin
            rdMux = '0;
         end
      endcase
   end

   // next-state logic for the whole block
   always_comb begin
      d        = q;
      d.strapM = bootStrapPins;
      d.strapS = q.strapM;
      d.rxM    = uartRx;
      d.rxS    = q.rxM;
      d.misoM  = flashMiso;
      d.misoS  = q.misoM;
      d.rdy    = psel && !(penable && q.rdy);
      if (psel) begin
         d.rdata = rdMux;
      end

      // boot mode sequencer
      unique case (q.st)
         boot_loader_pkg::BOOT_STRAP: begin
            // straps are sampled once the synchroniser holds post-reset levels
            if (q.settle == boot_loader_pkg::SETTLE_LAST) begin
               d.strap = q.strapS;
               if (q.strapS == boot_loader_pkg::STRAP_LOAD) begin
                  d.st       = boot_loader_pkg::BOOT_LOAD; // R4
                  d.fourWire = 1'b1; // R6
               end else if (q.strapS == boot_loader_pkg::STRAP_LOR) begin
                  d.st       = boot_loader_pkg::BOOT_DETECT; // R7
                  d.fourWire = 1'b1; // R9
                  d.dbgAvail = 1'b1; // R9
                  d.waitCnt  = '0;
               end else begin
                  d.st = boot_loader_pkg::BOOT_RUN;
               end
            end else begin
               d.settle = q.settle + 2'h1;
            end
         end
         boot_loader_pkg::BOOT_DETECT: begin
            if (rxBreak) begin
               d.st = boot_loader_pkg::BOOT_LOAD; // R8
            end else if (q.waitCnt == WAIT_LAST) begin
               d.st = boot_loader_pkg::BOOT_RUN; // R8
            end else begin
               d.waitCnt = q.waitCnt + 24'h1;
            end
         end
         boot_loader_pkg::BOOT_LOAD: begin
            // no timeout: only a reset with new straps leaves this state
            d.st = boot_loader_pkg::BOOT_LOAD; // R4
         end
         boot_loader_pkg::BOOT_RUN: begin
            d.st = boot_loader_pkg::BOOT_RUN;
         end
      endcase

      // received image bytes; a newly arriving byte wins over a read clear
      if (rdHit && paddr == boot_loader_pkg::OFS_RXDATA) begin
         d.rxValid = 1'b0;
      end
      if (wrHit && paddr == boot_loader_pkg::OFS_STATUS) begin
         if (pwdata[boot_loader_pkg::STS_OVERRUN]) d.overrun = 1'b0;
         if (pwdata[boot_loader_pkg::STS_FRAMEERR]) d.ferr = 1'b0;
         if (pwdata[boot_loader_pkg::STS_BREAK]) d.brkSeen = 1'b0;
      end
      if (wrHit && paddr == boot_loader_pkg::OFS_COUNT) begin
         d.count = '0; // R1
      end
      if (rxDone && q.st == boot_loader_pkg::BOOT_LOAD) begin
         d.overrun = d.overrun | d.rxValid;
         d.rxValid = 1'b1; // R12
         d.rxByte  = rxData;
         d.count   = d.count + 24'h1; // R1
      end
      if (rxFerr && q.st == boot_loader_pkg::BOOT_LOAD) begin
         d.ferr = 1'b1;
      end
      if (rxBreak && q.st == boot_loader_pkg::BOOT_DETECT) begin
         d.brkSeen = 1'b1; // R8
      end

      // software control of the flash pins
      if (wrHit && paddr == boot_loader_pkg::OFS_CTRL) begin
         d.flashEn = pwdata[boot_loader_pkg::CTRL_FLASH_EN]; // R2
      end
      if (wrHit && paddr == boot_loader_pkg::OFS_FLASHIO) begin
         d.fio = pwdata[boot_loader_pkg::FIO_SCLK +: 3];
      end
   end

   // single state register; clock enable low freezes everything
   always_ff @(posedge mclk) begin
      if (rst) begin
         q     <= '0;
         q.fio <= boot_loader_pkg::FIO_RESET;
      end else if (clkEn) begin
         q <= d;
      end
   end

   // apb answer; a frozen clock enable stretches the access
   assign pready  = q.rdy && clkEn;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = q.rdata;

   // flash pins released during reset so an outside programmer owns them
   assign flashOe   = q.flashEn && !rst; // R3
   assign flashSclk = q.fio[boot_loader_pkg::FIO_SCLK];
   assign flashCsN  = q.fio[boot_loader_pkg::FIO_CS_N];
   assign flashMosi = q.fio[boot_loader_pkg::FIO_MOSI];

   // transmit line idles high; the reply protocol sits above this block
   assign uartTx = 1'b1; // R13

   assign bootState      = q.st;
   assign serialLoadMode = q.st == boot_loader_pkg::BOOT_LOAD;
   assign runMode        = q.st == boot_loader_pkg::BOOT_RUN;
   assign jtagFourWire   = q.fourWire;
   assign debugPortAvail = q.dbgAvail;

   sequence s_strap_done;
      q.st == boot_loader_pkg::BOOT_STRAP && q.settle == boot_loader_pkg::SETTLE_LAST && clkEn;
   endsequence

   sequence s_detect_break;
      q.st == boot_loader_pkg::BOOT_DETECT && rxBreak && clkEn;
   endsequence

   a_flash_released: assert property (@(posedge mclk) disable iff (1'b0) // R3
      rst |-> !flashOe)
      else $error("flash lines driven during reset");

   a_load_holds: assert property (@(posedge mclk) disable iff (rst) // R4
      serialLoadMode |=> serialLoadMode [*8])
      else $error("serial load mode left without reset");

   a_load_strap_entry: assert property (@(posedge mclk) disable iff (rst) // R4
      s_strap_done and (q.strapS == boot_loader_pkg::STRAP_LOAD) |=> serialLoadMode
         && jtagFourWire && !debugPortAvail)
      else $error("load straps did not enter serial load");

   a_load_four_wire: assert property (@(posedge mclk) disable iff (rst) // R6
      serialLoadMode |-> jtagFourWire)
      else $error("serial load without four-wire debug port");

   a_lor_detect: assert property (@(posedge mclk) disable iff (rst) // R7
      s_strap_done and (q.strapS == boot_loader_pkg::STRAP_LOR) |=>
         bootState == boot_loader_pkg::BOOT_DETECT && q.waitCnt == 24'h0)
      else $error("load-or-run straps did not start break watch");

   a_break_to_load: assert property (@(posedge mclk) disable iff (rst) // R8
      s_detect_break |=> serialLoadMode && q.brkSeen)
      else $error("break in load-or-run did not enter serial load");

   a_timeout_run: assert property (@(posedge mclk) disable iff (rst) // R8
      (q.st == boot_loader_pkg::BOOT_DETECT && q.waitCnt == WAIT_LAST && !rxBreak && clkEn)
         |=> runMode)
      else $error("no break but not in functional operation");

   a_lor_debug: assert property (@(posedge mclk) disable iff (rst) // R9
      bootState == boot_loader_pkg::BOOT_DETECT |-> debugPortAvail && jtagFourWire)
      else $error("debug port not kept in load-or-run mode");

   a_byte_counted: assert property (@(posedge mclk) disable iff (rst) // R12
      (rxDone && serialLoadMode && clkEn && !wrHit) |=> q.rxValid
         && q.rxByte == $past(rxData) && q.count == $past(q.count) + 24'h1)
      else $error("received byte not stored and counted");

   a_tx_idle: assert property (@(posedge mclk) disable iff (rst) // R13
      !serialLoadMode |-> uartTx)
      else $error("transmit line left idle state");
endmodule : boot_mode_serial_image_loader
`default_nettype wire

// *** test/programmer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural production programmer: reset pin, strap pulls, serial line, flash data pin
module programmer_model #(
   parameter int BIT_CYC = boot_loader_pkg::BIT_CYC
) (
   input  wire logic       mclk,
   output logic            chipResetN,
   output logic [2:0]      bootStrapPins,
   output logic            uartRx,
   output logic            flashMiso
);
   // device starts held in reset, line idles high through its pull-up
   initial begin
      chipResetN    = 1'b0;
      bootStrapPins = 3'h0;
      uartRx        = 1'b1;
      flashMiso     = 1'b0;
   end

   // straps change only while reset is held, so they are stable at release
   task automatic hold_reset(input logic [2:0] straps);
      @(posedge mclk);
      chipResetN    <= 1'b0;
      bootStrapPins <= straps;
   endtask : hold_reset

   task automatic release_reset();
      @(posedge mclk);
      chipResetN <= 1'b1;
   endtask : release_reset

   // entered just after an edge; one data line only, no handshake
   task automatic send_frame(input logic [7:0] data, input logic stopBit);
      logic [9:0] frame;
      frame = {stopBit, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         uartRx <= frame[i];
         repeat (BIT_CYC) @(posedge mclk);
      end
   endtask : send_frame

   // low span; a break only when longer than a whole frame
   task automatic send_low(input int cycles);
      uartRx <= 1'b0;
      repeat (cycles) @(posedge mclk);
      uartRx <= 1'b1;
      @(posedge mclk);
   endtask : send_low

   task automatic set_miso(input logic level);
      flashMiso <= level;
      @(posedge mclk);
   endtask : set_miso
endmodule : programmer_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int WAIT_CYC = 2000;
   logic        mclk;
   logic        rst;
   logic        clkEn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  bootStrapPins;
   logic        uartRx;
   logic        uartTx;
   logic        flashMiso;
   logic        flashSclk;
   logic        flashCsN;
   logic        flashMosi;
   logic        flashOe;
   logic [1:0]  bootState;
   logic        serialLoadMode;
   logic        runMode;
   logic        jtagFourWire;
   logic        debugPortAvail;
   logic        chipResetN;
   int          miscompares;
   int          n_compared;

   boot_mode_serial_image_loader #(.BREAK_WAIT_CYC(WAIT_CYC)) boot_mode_serial_image_loader_inst (
      .mclk(mclk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bootStrapPins(bootStrapPins), .uartRx(uartRx), .uartTx(uartTx), .flashMiso(flashMiso),
      .flashSclk(flashSclk), .flashCsN(flashCsN), .flashMosi(flashMosi), .flashOe(flashOe),
      .bootState(bootState), .serialLoadMode(serialLoadMode), .runMode(runMode),
      .jtagFourWire(jtagFourWire), .debugPortAvail(debugPortAvail));

   programmer_model programmer_model_inst (
      .mclk(mclk), .chipResetN(chipResetN), .bootStrapPins(bootStrapPins), .uartRx(uartRx),
      .flashMiso(flashMiso));

   // the pin is active low, the block takes an active-high reset
   assign rst = ~chipResetN;

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // one apb transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // with the clock enable high the slave answers in the first access cycle
      check(32'(n), 32'h1, "access wait states");
   endtask : apb

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] d;
      logic        e;
      apb(1'b1, addr, data, d, e);
   endtask : wr

   task automatic rd_check(input logic [7:0] addr, input logic [31:0] mask,
                           input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic        e;
      apb(1'b0, addr, 32'h0, d, e);
      check(d & mask, exp, what);
      check({31'h0, e}, 32'h0, "error flag");
   endtask : rd_check

   task automatic restart(input logic [2:0] straps);
      programmer_model_inst.hold_reset(straps);
      repeat (8) @(posedge mclk);
      programmer_model_inst.release_reset();
      repeat (12) @(posedge mclk);
   endtask : restart

   // generous bound: the whole sequence needs about 14.5k cycles
   initial begin
      repeat (40000) @(posedge mclk);
      miscompares++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      test_done();
   end

   initial begin
      logic [31:0] d;
      logic        e;
      miscompares = 0;
      n_compared  = 0;
      clkEn   = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      // load straps: waits forever, four-wire debug
      restart(3'h4);
      check(32'(bootState), 32'(boot_loader_pkg::BOOT_LOAD), "load state");
      check({30'h0, jtagFourWire, debugPortAvail}, 32'h2, "debug port");
      repeat (3000) @(posedge mclk);
      check({30'h0, serialLoadMode, runMode}, 32'h2, "still loading");
      check({31'h0, uartTx}, 32'h1, "tx idle");
      programmer_model_inst.send_frame(8'ha5, 1'b1);
      programmer_model_inst.send_frame(8'h3c, 1'b1);
      repeat (20) @(posedge mclk);
      rd_check(boot_loader_pkg::OFS_STATUS, 32'hff, 32'h4d, "status two bytes");
      rd_check(boot_loader_pkg::OFS_COUNT, 32'hffffff, 32'h2, "byte count");
      rd_check(boot_loader_pkg::OFS_RXDATA, 32'hff, 32'h3c, "last byte");
      rd_check(boot_loader_pkg::OFS_STATUS, 32'hff, 32'h49, "valid cleared");
      wr(boot_loader_pkg::OFS_STATUS, 32'h08);
      rd_check(boot_loader_pkg::OFS_STATUS, 32'hff, 32'h41, "overrun cleared");
      programmer_model_inst.send_frame(8'h55, 1'b0);
      programmer_model_inst.send_low(1);
      repeat (300) @(posedge mclk);
      rd_check(boot_loader_pkg::OFS_STATUS, 32'h10, 32'h10, "low stop bit");
      wr(boot_loader_pkg::OFS_CTRL, 32'h1);
      wr(boot_loader_pkg::OFS_FLASHIO, 32'h5);
      programmer_model_inst.set_miso(1'b1);
      repeat (4) @(posedge mclk);
      check({28'h0, flashOe, flashMosi, flashCsN, flashSclk}, 32'hd, "flash pins");
      rd_check(boot_loader_pkg::OFS_FLASHIO, 32'hf, 32'hd, "flash io");
      apb(1'b0, 8'h20, 32'h0, d, e);
      check({e, d[30:0]}, 32'h80000000, "unmapped read");
      // reset in mid-load releases the shared flash lines
      programmer_model_inst.hold_reset(3'h2);
      repeat (2) @(posedge mclk);
      check({29'h0, flashOe, serialLoadMode, runMode}, 32'h0, "lines released");
      repeat (6) @(posedge mclk);
      programmer_model_inst.release_reset();
      $display("load straps test done");
      // load-or-run with a real break
      repeat (12) @(posedge mclk);
      check(32'(bootState), 32'(boot_loader_pkg::BOOT_DETECT), "break watch");
      check({31'h0, debugPortAvail}, 32'h1, "debugger pins");
      programmer_model_inst.send_low(1500);
      repeat (20) @(posedge mclk);
      check(32'(bootState), 32'(boot_loader_pkg::BOOT_LOAD), "break enters load");
      rd_check(boot_loader_pkg::OFS_STATUS, 32'he3, 32'he1, "break seen");
      $display("break test done");
      // load-or-run with a low span shorter than a frame
      restart(3'h2);
      // a low clock enable freezes the break window, so no timeout yet
      clkEn <= 1'b0;
      repeat (WAIT_CYC) @(posedge mclk);
      check(32'(bootState), 32'(boot_loader_pkg::BOOT_DETECT), "frozen break watch");
      clkEn <= 1'b1;
      programmer_model_inst.send_low(1000);
      repeat (WAIT_CYC - 900) @(posedge mclk);
      check({30'h0, serialLoadMode, runMode}, 32'h1, "short low runs");
      $display("no break test done");
      // functional straps restored after production
      restart(3'h0);
      check({29'h0, runMode, jtagFourWire, debugPortAvail}, 32'h4, "functional run");
      programmer_model_inst.send_frame(8'h11, 1'b1);
      rd_check(boot_loader_pkg::OFS_COUNT, 32'hffffff, 32'h0, "ignored byte");
      $display("functional test done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
